/* File: urc_defines.vh */
`ifndef URC_DEFINES_VH
`define URC_DEFINES_VH
// register offsets
`define URC_OFS_DATA 3'h0
`define URC_OFS_IEN 3'h1
`define URC_OFS_IID 3'h2
`define URC_OFS_LCTL 3'h3
`define URC_OFS_MCTL 3'h4
`define URC_OFS_LSTAT 3'h5
`define URC_OFS_MSTAT 3'h6
`define URC_OFS_SCR 3'h7
// line_control field positions
`define URC_LC_STOP 2
`define URC_LC_PAR_EN 3
`define URC_LC_EVEN 4
`define URC_LC_STICK 5
`define URC_LC_BREAK 6
`define URC_LC_DIV_SEL 7
// modem_control field positions
`define URC_MC_OUT2 3
`define URC_MC_LOOP 4
// interrupt_ident codes
`define URC_IID_LINE 3'h6
`define URC_IID_RXDATA 3'h4
`define URC_IID_HOLDING_EMPTY_FLAG 3'h2
`define URC_IID_MODEM 3'h0
`define URC_IID_NONE 3'h1
// reset values
`define URC_RST_ZERO 8'h00
`define URC_RST_DIV 16'h0001
// timing counts in 16x sample ticks
`define URC_TICKS_BIT 5'h10
`define URC_TICKS_STOP_HALF 5'h18
`define URC_TICKS_STOP_TWO 6'h20
`define URC_START_MID 4'h7
`define URC_SAMPLE_PT 4'hf
`endif

/* File: urc_core.v */
`timescale 1ns/1ps
`include "urc_defines.vh"
module urc_core (
  input wire clk,
  input wire srst,
  input wire [2:0] hostAddr,
  input wire hostWrEn,
  input wire hostRdEn,
  input wire [7:0] hostWrData,
  output reg [7:0] hostRdData_ff,
  input wire serialInputPin,
  output reg serialOutputPin_ff,
  input wire ctsN,
  input wire dsrN,
  input wire riN,
  input wire rlsdN,
  output reg dtrN_ff,
  output reg rtsN_ff,
  output reg out1N_ff,
  output reg out2N_ff,
  output reg interruptRequestOut_ff
);

  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_PAR = 3'd3;
  localparam ST_STOP = 3'd4;

  // parity bit to send or expect for the current format
  function parity_bit;
    input [7:0] data;
    input [7:0] lc;
    reg [7:0] mask;
    begin
      case (lc[1:0])
        2'd0: mask = 8'h1f;
        2'd1: mask = 8'h3f;
        2'd2: mask = 8'h7f;
        default: mask = 8'hff;
      endcase
      if (lc[`URC_LC_STICK])
        parity_bit = ~lc[`URC_LC_EVEN];
      else
        parity_bit = (^(data & mask)) ^ ~lc[`URC_LC_EVEN];
    end
  endfunction

  reg [7:0] lineCtl_ff;
  reg [7:0] modemCtl_ff;
  reg [3:0] intEn_ff;
  reg [15:0] divisor_ff;
  reg [7:0] scratch_ff;
  reg [7:0] rxBuf_ff;
  reg [7:0] txHold_ff;
  reg txFull_ff;
  reg thrIrq_ff;
  reg dataReady_ff;
  reg overrun_ff;
  reg parErr_ff;
  reg frameErr_ff;
  reg breakDet_ff;
  reg [3:0] mdmDelta_ff;
  reg [3:0] mdmPrev_ff;
  reg [15:0] baudCnt_ff;
  reg tick_ff;
  reg [4:0] pinSync1_ff;
  reg [4:0] pinSync2_ff;
  reg [4:0] pinSync3_ff;
  reg [4:0] pinFilt_ff;
  reg [2:0] rxState_ff;
  reg [3:0] rxCnt_ff;
  reg [2:0] rxIdx_ff;
  reg [7:0] rxSh_ff;
  reg rxPar_ff;
  reg rxZero_ff;
  reg [2:0] txState_ff;
  reg [5:0] txCnt_ff;
  reg [2:0] txIdx_ff;
  reg [7:0] txSh_ff;
  reg txLine_ff;

  wire divSel = lineCtl_ff[`URC_LC_DIV_SEL];
  wire loopOn = modemCtl_ff[`URC_MC_LOOP];
  wire [2:0] lastIdx = 3'd4 + {1'b0, lineCtl_ff[1:0]};
  wire rxIn = loopOn ? txLine_ff : pinFilt_ff[0];
  // modem sources {rlsd, ri, dsr, cts}, active high
  wire [3:0] mdmNow = loopOn ? {modemCtl_ff[3], modemCtl_ff[2], modemCtl_ff[0], modemCtl_ff[1]}
                             : ~pinFilt_ff[4:1];
  wire txIdle = (txState_ff == ST_IDLE);
  wire [7:0] lineStat = {1'b0, ~txFull_ff & txIdle, ~txFull_ff, breakDet_ff, frameErr_ff,
                         parErr_ff, overrun_ff, dataReady_ff};
  wire [7:0] modemStat = {mdmNow, mdmDelta_ff};

  wire lsPend = intEn_ff[2] & (overrun_ff | parErr_ff | frameErr_ff | breakDet_ff);
  wire rdPend = intEn_ff[0] & dataReady_ff;
  wire thPend = intEn_ff[1] & thrIrq_ff;
  wire msPend = intEn_ff[3] & (|mdmDelta_ff);
  wire anyPend = lsPend | rdPend | thPend | msPend;

  reg [2:0] iidCode;
  always @*
  begin
    if (lsPend)
      iidCode = `URC_IID_LINE;
    else if (rdPend)
      iidCode = `URC_IID_RXDATA;
    else if (thPend)
      iidCode = `URC_IID_HOLDING_EMPTY_FLAG;
    else if (msPend)
      iidCode = `URC_IID_MODEM;
    else
      iidCode = `URC_IID_NONE;
  end

  reg [7:0] nxt_rdData;
  always @*
  begin
    case (hostAddr)
      `URC_OFS_DATA: nxt_rdData = divSel ? divisor_ff[7:0] : rxBuf_ff;
      `URC_OFS_IEN: nxt_rdData = divSel ? divisor_ff[15:8] : {4'h0, intEn_ff};
      `URC_OFS_IID: nxt_rdData = {5'h00, iidCode};
      `URC_OFS_LCTL: nxt_rdData = lineCtl_ff;
      `URC_OFS_MCTL: nxt_rdData = {3'h0, modemCtl_ff[4:0]};
      `URC_OFS_LSTAT: nxt_rdData = lineStat;
      `URC_OFS_MSTAT: nxt_rdData = modemStat;
      default: nxt_rdData = scratch_ff;
    endcase
  end

  wire rdBuf = hostRdEn & (hostAddr == `URC_OFS_DATA) & ~divSel;
  wire rdLine = hostRdEn & (hostAddr == `URC_OFS_LSTAT);
  wire rdModem = hostRdEn & (hostAddr == `URC_OFS_MSTAT);
  // clear only when the returned code names holding-empty
  wire rdIidThre = hostRdEn & (hostAddr == `URC_OFS_IID) & (iidCode == `URC_IID_HOLDING_EMPTY_FLAG);
  wire wrHold = hostWrEn & (hostAddr == `URC_OFS_DATA) & ~divSel;
  wire wrIen = hostWrEn & (hostAddr == `URC_OFS_IEN) & ~divSel;
  wire txLoad = txIdle & txFull_ff;
  wire rxSample = tick_ff & (rxCnt_ff == `URC_SAMPLE_PT);
  wire rxDone = rxSample & (rxState_ff == ST_STOP);

  // host register writes, outputs and read data
  always @(posedge clk)
  begin
    if (srst)
    begin
      lineCtl_ff <= `URC_RST_ZERO;
      modemCtl_ff <= `URC_RST_ZERO;
      intEn_ff <= 4'h0;
      divisor_ff <= `URC_RST_DIV;
      scratch_ff <= `URC_RST_ZERO;
      hostRdData_ff <= `URC_RST_ZERO;
      serialOutputPin_ff <= 1'b1;
      dtrN_ff <= 1'b1;
      rtsN_ff <= 1'b1;
      out1N_ff <= 1'b1;
      out2N_ff <= 1'b1;
      interruptRequestOut_ff <= 1'b0;
    end
    else
    begin
      if (hostRdEn)
        hostRdData_ff <= nxt_rdData;
      if (hostWrEn)
      begin
        case (hostAddr)
          `URC_OFS_DATA:
          begin
            if (divSel)
              divisor_ff[7:0] <= hostWrData;
          end
          `URC_OFS_IEN:
          begin
            if (divSel)
              divisor_ff[15:8] <= hostWrData;
            else
              intEn_ff <= hostWrData[3:0];
          end
          `URC_OFS_LCTL: lineCtl_ff <= hostWrData;
          `URC_OFS_MCTL: modemCtl_ff <= {3'h0, hostWrData[4:0]};
          `URC_OFS_SCR: scratch_ff <= hostWrData;
          default: scratch_ff <= scratch_ff;
        endcase
      end
      if (loopOn)
        serialOutputPin_ff <= 1'b1;
      else if (lineCtl_ff[`URC_LC_BREAK])
        serialOutputPin_ff <= 1'b0;
      else
        serialOutputPin_ff <= txLine_ff;
      dtrN_ff <= loopOn | ~modemCtl_ff[0];
      rtsN_ff <= loopOn | ~modemCtl_ff[1];
      out1N_ff <= loopOn | ~modemCtl_ff[2];
      out2N_ff <= loopOn | ~modemCtl_ff[3];
      interruptRequestOut_ff <= anyPend & modemCtl_ff[`URC_MC_OUT2] & ~loopOn;
    end
  end

  // 16x sample tick from the divisor, pin synchronisers
  always @(posedge clk)
  begin
    if (srst)
    begin
      baudCnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
      pinSync1_ff <= 5'h1f;
      pinSync2_ff <= 5'h1f;
      pinSync3_ff <= 5'h1f;
      pinFilt_ff <= 5'h1f;
      mdmPrev_ff <= 4'h0;
    end
    else
    begin
      if (baudCnt_ff + 16'h0001 >= divisor_ff)
      begin
        baudCnt_ff <= 16'h0000;
        tick_ff <= 1'b1;
      end
      else
      begin
        baudCnt_ff <= baudCnt_ff + 16'h0001;
        tick_ff <= 1'b0;
      end
      pinSync1_ff <= {rlsdN, riN, dsrN, ctsN, serialInputPin};
      pinSync2_ff <= pinSync1_ff;
      pinSync3_ff <= pinSync2_ff;
      pinFilt_ff <= (pinFilt_ff & ~(pinSync2_ff ^ pinSync3_ff))
                  | (pinSync2_ff & ~(pinSync2_ff ^ pinSync3_ff));
      mdmPrev_ff <= mdmNow;
    end
  end

  // status flags: a set in the same cycle as a clear wins, except thrIrq_ff, where a hold write clears it over a load
  always @(posedge clk)
  begin
    if (srst)
    begin
      dataReady_ff <= 1'b0;
      overrun_ff <= 1'b0;
      parErr_ff <= 1'b0;
      frameErr_ff <= 1'b0;
      breakDet_ff <= 1'b0;
      mdmDelta_ff <= 4'h0;
      thrIrq_ff <= 1'b0;
      txFull_ff <= 1'b0;
      txHold_ff <= `URC_RST_ZERO;
      rxBuf_ff <= `URC_RST_ZERO;
    end
    else
    begin
      if (rxDone)
      begin
        rxBuf_ff <= rxSh_ff;
        dataReady_ff <= 1'b1;
      end
      else if (rdBuf)
        dataReady_ff <= 1'b0;
      if (rxDone)
      begin
        overrun_ff <= overrun_ff | (dataReady_ff & ~rdBuf);
        parErr_ff <= parErr_ff | (lineCtl_ff[`URC_LC_PAR_EN]
                     & (rxPar_ff != parity_bit(rxSh_ff, lineCtl_ff)));
        frameErr_ff <= frameErr_ff | ~rxIn;
        breakDet_ff <= breakDet_ff | (rxZero_ff & ~rxIn);
      end
      else if (rdLine)
      begin
        overrun_ff <= 1'b0;
        parErr_ff <= 1'b0;
        frameErr_ff <= 1'b0;
        breakDet_ff <= 1'b0;
      end
      mdmDelta_ff <= (rdModem ? 4'h0 : mdmDelta_ff)
                   | {mdmNow[3] ^ mdmPrev_ff[3], ~mdmNow[2] & mdmPrev_ff[2],
                      mdmNow[1:0] ^ mdmPrev_ff[1:0]};
      if (wrHold)
      begin
        txHold_ff <= hostWrData;
        txFull_ff <= 1'b1;
      end
      else if (txLoad)
        txFull_ff <= 1'b0;
      if (txLoad & ~wrHold)
        thrIrq_ff <= 1'b1;
      else if (wrIen & hostWrData[1] & ~intEn_ff[1] & ~txFull_ff & ~wrHold)
        thrIrq_ff <= 1'b1;
      else if (wrHold | rdIidThre)
        thrIrq_ff <= 1'b0;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      rxState_ff <= ST_IDLE;
      rxCnt_ff <= 4'h0;
      rxIdx_ff <= 3'h0;
      rxSh_ff <= 8'h00;
      rxPar_ff <= 1'b0;
      rxZero_ff <= 1'b0;
    end
    else if (tick_ff)
    begin
      rxCnt_ff <= rxCnt_ff + 4'h1;
      case (rxState_ff)
        ST_IDLE:
        begin
          rxCnt_ff <= 4'h0;
          if (~rxIn)
            rxState_ff <= ST_START;
        end
        ST_START:
        begin
          if (rxCnt_ff == `URC_START_MID)
          begin
            rxCnt_ff <= 4'h0;
            rxIdx_ff <= 3'h0;
            rxSh_ff <= 8'h00;
            rxZero_ff <= 1'b1;
            rxState_ff <= rxIn ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (rxCnt_ff == `URC_SAMPLE_PT)
          begin
            rxSh_ff[rxIdx_ff] <= rxIn;
            rxZero_ff <= rxZero_ff & ~rxIn;
            rxIdx_ff <= rxIdx_ff + 3'h1;
            if (rxIdx_ff == lastIdx)
              rxState_ff <= lineCtl_ff[`URC_LC_PAR_EN] ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR:
        begin
          if (rxCnt_ff == `URC_SAMPLE_PT)
          begin
            rxPar_ff <= rxIn;
            rxZero_ff <= rxZero_ff & ~rxIn;
            rxState_ff <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (rxCnt_ff == `URC_SAMPLE_PT)
            rxState_ff <= ST_IDLE;
        end
        default: rxState_ff <= ST_IDLE;
      endcase
    end
  end

  // transmitter; stop length counted in ticks
  wire [5:0] stopTicks = ~lineCtl_ff[`URC_LC_STOP] ? {1'b0, `URC_TICKS_BIT}
                       : (lineCtl_ff[1:0] == 2'd0) ? {1'b0, `URC_TICKS_STOP_HALF}
                       : `URC_TICKS_STOP_TWO;
  wire bitEnd = tick_ff & (txCnt_ff == {1'b0, `URC_TICKS_BIT} - 6'd1);

  always @(posedge clk)
  begin
    if (srst)
    begin
      txState_ff <= ST_IDLE;
      txCnt_ff <= 6'h00;
      txIdx_ff <= 3'h0;
      txSh_ff <= 8'h00;
      txLine_ff <= 1'b1;
    end
    else
    begin
      if (tick_ff)
        txCnt_ff <= txCnt_ff + 6'd1;
      case (txState_ff)
        ST_IDLE:
        begin
          txCnt_ff <= 6'h00;
          if (txLoad)
          begin
            txSh_ff <= txHold_ff;
            txLine_ff <= 1'b0;
            txState_ff <= ST_START;
          end
        end
        ST_START:
        begin
          if (bitEnd)
          begin
            txCnt_ff <= 6'h00;
            txIdx_ff <= 3'h0;
            txLine_ff <= txSh_ff[0];
            txState_ff <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (bitEnd)
          begin
            txCnt_ff <= 6'h00;
            txIdx_ff <= txIdx_ff + 3'h1;
            txLine_ff <= txSh_ff[txIdx_ff + 3'h1];
            if (txIdx_ff == lastIdx)
            begin
              if (lineCtl_ff[`URC_LC_PAR_EN])
              begin
                txLine_ff <= parity_bit(txSh_ff, lineCtl_ff);
                txState_ff <= ST_PAR;
              end
              else
              begin
                txLine_ff <= 1'b1;
                txState_ff <= ST_STOP;
              end
            end
          end
        end
        ST_PAR:
        begin
          if (bitEnd)
          begin
            txCnt_ff <= 6'h00;
            txLine_ff <= 1'b1;
            txState_ff <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (tick_ff & (txCnt_ff == stopTicks - 6'd1))
          begin
            txCnt_ff <= 6'h00;
            txState_ff <= ST_IDLE;
          end
        end
        default: txState_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // urc_core

/* File: urc_core_sva.sv */
`timescale 1ns/1ps
module urc_core_sva (
  input wire clk,
  input wire srst,
  input wire [2:0] hostAddr,
  input wire hostWrEn,
  input wire hostRdEn,
  input wire [7:0] hostWrData,
  input wire [7:0] hostRdData_ff,
  input wire serialOutputPin_ff,
  input wire dtrN_ff,
  input wire out2N_ff,
  input wire interruptRequestOut_ff
);
  reg [7:0] lcrSh_ff;
  reg [3:0] ienSh_ff;
  reg [4:0] mcrSh_ff;
  // shadows of the host-written control registers
  always @(posedge clk)
  begin
    if (srst)
    begin
      lcrSh_ff <= 8'h00;
      ienSh_ff <= 4'h0;
      mcrSh_ff <= 5'h00;
    end
    else if (hostWrEn)
    begin
      if (hostAddr == 3'h3)
        lcrSh_ff <= hostWrData;
      if (hostAddr == 3'h1 && !lcrSh_ff[7])
        ienSh_ff <= hostWrData[3:0];
      if (hostAddr == 3'h4)
        mcrSh_ff <= hostWrData[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rd(logic [2:0] a);
    hostRdEn && hostAddr == a;
  endsequence
  sequence s_wr(logic [2:0] a);
    hostWrEn && hostAddr == a;
  endsequence
  sequence s_gateOff;
    !mcrSh_ff[3] ##1 !mcrSh_ff[3];
  endsequence
  sequence s_ienOff;
    ienSh_ff == 4'h0 ##1 ienSh_ff == 4'h0;
  endsequence
  property p_rstOut;
    $fell(srst) |-> serialOutputPin_ff && dtrN_ff && out2N_ff && !interruptRequestOut_ff
      && hostRdData_ff == 8'h00;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("outputs wrong after reset");
  property p_iidCode;
    s_rd(3'h2) |=> hostRdData_ff[7:3] == 5'h00 && (!hostRdData_ff[0] || hostRdData_ff[2:1] == 2'b00);
  endproperty
  a_iidCode: assert property (p_iidCode) else $error("ident code malformed");
  property p_iidIdle;
    s_ienOff ##0 s_rd(3'h2) |=> hostRdData_ff == 8'h01;
  endproperty
  a_iidIdle: assert property (p_iidIdle) else $error("ident pending with enables off");
  property p_ienHigh;
    s_rd(3'h1) ##0 !lcrSh_ff[7] |=> hostRdData_ff[7:4] == 4'h0;
  endproperty
  a_ienHigh: assert property (p_ienHigh) else $error("enable upper bits not zero");
  property p_lcrBack;
    s_rd(3'h3) |=> hostRdData_ff == $past(lcrSh_ff);
  endproperty
  a_lcrBack: assert property (p_lcrBack) else $error("line control readback wrong");
  property p_irqOff;
    s_ienOff |-> !interruptRequestOut_ff;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("interrupt with enables off");
  property p_irqGate;
    s_gateOff |-> !interruptRequestOut_ff;
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("interrupt with gate off");
  property p_brk;
    lcrSh_ff[6] && !mcrSh_ff[4] ##1 lcrSh_ff[6] && !mcrSh_ff[4] |-> !serialOutputPin_ff;
  endproperty
  a_brk: assert property (p_brk) else $error("break not forcing line low");
  property p_modemOut;
    s_wr(3'h4) |=> ##[0:2] (dtrN_ff == !(mcrSh_ff[0] && !mcrSh_ff[4])
      && out2N_ff == !(mcrSh_ff[3] && !mcrSh_ff[4]));
  endproperty
  a_modemOut: assert property (p_modemOut) else $error("modem outputs wrong");
  property p_irqSrc;
    s_rd(3'h2) ##1 (!hostRdData_ff[0] && hostRdData_ff[2:1] != 2'b01 && mcrSh_ff[3]
      && !mcrSh_ff[4]) |-> interruptRequestOut_ff;
  endproperty
  a_irqSrc: assert property (p_irqSrc) else $error("pending source without interrupt");
endmodule // urc_core_sva
bind urc_core urc_core_sva u_sva (
  .clk(clk),
  .srst(srst),
  .hostAddr(hostAddr),
  .hostWrEn(hostWrEn),
  .hostRdEn(hostRdEn),
  .hostWrData(hostWrData),
  .hostRdData_ff(hostRdData_ff),
  .serialOutputPin_ff(serialOutputPin_ff),
  .dtrN_ff(dtrN_ff),
  .out2N_ff(out2N_ff),
  .interruptRequestOut_ff(interruptRequestOut_ff)
);

/* File: urc_peer.sv */
`timescale 1ns/1ps
module urc_peer (
  input wire clk,
  input wire rxLine,
  output reg txLine
);
  integer i;
  integer j;
  integer k;
  initial txLine = 1'b1;
  task send(input [10:0] bits, input integer n);
    begin
      @(negedge clk);
      txLine = 1'b0;
      repeat (16) @(negedge clk);
      for (i = 0; i < n; i = i + 1)
      begin
        txLine = bits[i];
        repeat (16) @(negedge clk);
      end
      txLine = 1'b1;
    end
  endtask
  task capture(input integer n, output [10:0] w);
    begin
      w = 11'h000;
      k = 0;
      while (rxLine === 1'b1 && k < 400)
      begin
        @(negedge clk);
        k = k + 1;
      end
      repeat (8) @(negedge clk);
      for (j = 0; j < n; j = j + 1)
      begin
        repeat (16) @(negedge clk);
        w[j] = rxLine;
      end
    end
  endtask
endmodule // urc_peer

/* File: urc_tb.sv */
`timescale 1ns/1ps
module testbench;
  reg clk;
  reg srst;
  reg hostWrEn;
  reg hostRdEn;
  reg ctsN;
  reg dsrN;
  reg riN;
  reg rlsdN;
  reg [2:0] hostAddr;
  reg [7:0] hostWrData;
  reg [7:0] lcrV;
  reg [7:0] d;
  reg [7:0] m;
  reg [10:0] w;
  reg [10:0] e;
  reg [7:0] fmt [0:4];
  wire [7:0] rdData;
  wire serial_output_pin;
  wire serial_input_pin;
  wire irq;
  wire dtrN;
  wire rtsN;
  wire out1N;
  wire out2N;
  integer miscompares;
  integer nChecks;
  integer nb;
  integer i;
  urc_core u_dut (.clk(clk), .srst(srst), .hostAddr(hostAddr), .hostWrEn(hostWrEn),
    .hostRdEn(hostRdEn), .hostWrData(hostWrData), .hostRdData_ff(rdData),
    .serialInputPin(serial_input_pin), .serialOutputPin_ff(serial_output_pin), .ctsN(ctsN), .dsrN(dsrN),
    .riN(riN), .rlsdN(rlsdN), .dtrN_ff(dtrN), .rtsN_ff(rtsN), .out1N_ff(out1N),
    .out2N_ff(out2N),
    .interruptRequestOut_ff(irq));
  urc_peer u_peer (.clk(clk), .rxLine(serial_output_pin), .txLine(serial_input_pin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task wr(input [2:0] a, input [7:0] v);
    begin
      @(negedge clk);
      hostAddr = a;
      hostWrData = v;
      hostWrEn = 1'b1;
      @(negedge clk);
      hostWrEn = 1'b0;
    end
  endtask
  task chk(input [8*7:1] nm, input [15:0] ex, input [15:0] got);
    begin
      nChecks = nChecks + 1;
      if (got !== ex)
      begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task rc(input [2:0] a, input [7:0] ex);
    begin
      @(negedge clk);
      hostAddr = a;
      hostRdEn = 1'b1;
      @(negedge clk);
      hostRdEn = 1'b0;
      chk({"reg", 8'h30 + {5'h00, a}}, {8'h00, ex}, {8'h00, rdData});
    end
  endtask
  task irqIs(input v);
    begin
      repeat (2) @(negedge clk);
      chk("irq", {15'h0000, v}, {15'h0000, irq});
    end
  endtask
  task finalReport;
    begin
      $display("checks %0d miscompares %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares = miscompares + 1;
    finalReport;
  end
  initial
  begin
    miscompares = 0;
    nChecks = 0;
    srst = 1'b1;
    hostWrEn = 1'b0;
    hostRdEn = 1'b0;
    hostAddr = 3'h0;
    hostWrData = 8'h00;
    ctsN = 1'b1;
    dsrN = 1'b1;
    riN = 1'b1;
    rlsdN = 1'b1;
    fmt[0] = 8'h03;
    fmt[1] = 8'h1c;
    fmt[2] = 8'h0a;
    fmt[3] = 8'h3b;
    fmt[4] = 8'h2a;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    rc(3'h2, 8'h01);
    rc(3'h5, 8'h60);
    rc(3'h1, 8'h00);
    rc(3'h3, 8'h00);
    rc(3'h4, 8'h00);
    wr(3'h3, 8'h9b);
    rc(3'h3, 8'h9b);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    rc(3'h0, 8'h34);
    rc(3'h1, 8'h12);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rc(3'h1, 8'h00);
    wr(3'h2, 8'hff);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'hff);
    rc(3'h1, 8'h0f);
    rc(3'h2, 8'h02);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'h00);
    fork
      begin
        u_peer.capture(9, w);
        chk("txA", 16'h01c3, {5'h00, w});
        u_peer.capture(9, w);
        chk("txB", 16'h013c, {5'h00, w});
      end
      begin
        wr(3'h0, 8'hc3);
        wr(3'h0, 8'h3c);
        rc(3'h5, 8'h00);
      end
    join
    repeat (40) @(negedge clk);
    for (i = 0; i < 5; i = i + 1)
    begin
      lcrV = fmt[i];
      d = 8'hb4 + i;
      nb = lcrV[1:0] + 5;
      m = d & ((8'h01 << nb) - 8'h01);
      e = {3'h0, m};
      if (lcrV[3])
        e[nb] = lcrV[5] ? !lcrV[4] : (^m) ^ !lcrV[4];
      e[nb + lcrV[3]] = 1'b1;
      wr(3'h3, lcrV);
      fork
        u_peer.capture(nb + lcrV[3] + 1, w);
        wr(3'h0, d);
      join
      chk("txFmt", {5'h00, e}, {5'h00, w});
      repeat (40) @(negedge clk);
    end
    wr(3'h3, 8'h43);
    repeat (3) @(negedge clk);
    chk("brkOn", 16'h0000, {15'h0000, serial_output_pin});
    wr(3'h3, 8'h03);
    repeat (3) @(negedge clk);
    chk("brkOff", 16'h0001, {15'h0000, serial_output_pin});
    wr(3'h4, 8'h08);
    wr(3'h1, 8'h01);
    u_peer.send(11'h13c, 9);
    irqIs(1'b1);
    rc(3'h2, 8'h04);
    rc(3'h0, 8'h3c);
    rc(3'h2, 8'h01);
    irqIs(1'b0);
    wr(3'h1, 8'h05);
    u_peer.send(11'h081, 9);
    repeat (8) @(negedge clk);
    rc(3'h2, 8'h06);
    wr(3'h4, 8'h00);
    irqIs(1'b0);
    wr(3'h4, 8'h08);
    rc(3'h5, 8'h69);
    rc(3'h2, 8'h04);
    rc(3'h0, 8'h81);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'h08);
    ctsN = 1'b0;
    repeat (8) @(negedge clk);
    rc(3'h2, 8'h00);
    rc(3'h6, 8'h11);
    rc(3'h2, 8'h01);
    ctsN = 1'b1;
    repeat (8) @(negedge clk);
    wr(3'h1, 8'h0a);
    rc(3'h2, 8'h02);
    rc(3'h2, 8'h00);
    wr(3'h1, 8'h00);
    irqIs(1'b0);
    rc(3'h2, 8'h01);
    rc(3'h6, 8'h01);
    riN = 1'b0;
    dsrN = 1'b0;
    repeat (8) @(negedge clk);
    rc(3'h6, 8'h62);
    riN = 1'b1;
    rlsdN = 1'b0;
    repeat (8) @(negedge clk);
    rc(3'h6, 8'hac);
    wr(3'h3, 8'h1b);
    u_peer.send(11'h201, 10);
    repeat (8) @(negedge clk);
    rc(3'h5, 8'h65);
    rc(3'h0, 8'h01);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h03);
    repeat (2) @(negedge clk);
    chk("mdmOut", 16'h0013, {11'h000, serial_output_pin, dtrN, rtsN, out1N, out2N});
    wr(3'h1, 8'h01);
    wr(3'h4, 8'h1f);
    rc(3'h6, 8'hf1);
    wr(3'h0, 8'h5a);
    repeat (40) @(negedge clk);
    chk("loopOut", 16'h001f, {11'h000, serial_output_pin, dtrN, rtsN, out1N, out2N});
    repeat (130) @(negedge clk);
    irqIs(1'b0);
    rc(3'h2, 8'h04);
    rc(3'h5, 8'h61);
    rc(3'h0, 8'h5a);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h00);
    finalReport;
  end
endmodule // testbench
